// File: design/config_key_unlock.sv
// unlock key register bank with protected register write gating
`timescale 1ns/1ps
`include "config_key_unlock_consts.svh"
// Behaviour
// [RULE_01] an eight-bit unlock key lives at 1Fh, reset to zero.
// [RULE_02] the oscillator control register takes a write only while the key holds A1h.
// [RULE_03] trickle charge (20h) and comparator reference (21h) take writes only under 9Dh.
// [RULE_04] every register write other than a write to the key itself returns the key to 00h.
// [RULE_05] while the switch pin lock is set, the power switch pin level bit cannot change.
module config_key_unlock (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    output logic [7:0] UNLOCK_KEY,
    output logic [7:0] OSC_CONTROL,
    output logic [7:0] TRICKLE,
    output logic [7:0] COMP_REF,
    output logic POWER_SWITCH_PIN_LEVEL
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [7:0] unlock_key;
    logic [7:0] osc_status;
    logic [7:0] osc_control;
    logic [7:0] configuration;
    logic [7:0] trickle;
    logic [7:0] comp_ref;
    logic [7:0] next_unlock_key;
    logic [7:0] next_configuration;
    logic [7:0] next_rdata;
    config_key_unlock_pkg::gate_e gate;
    logic allowed;
    logic write_key;
    logic write_osc_control;
    logic write_trickle;
    logic write_comp_ref;
    logic write_osc_status;
    logic write_configuration;

    // ----------------------------------------
    // address decode
    // ----------------------------------------

    // which key a target address needs
    function automatic config_key_unlock_pkg::gate_e gate_of(input logic [7:0] a);
        case (a)
            `ADDR_OSC_CONTROL: gate_of = config_key_unlock_pkg::GATE_OSC;
            `ADDR_TRICKLE, `ADDR_COMP_REF: gate_of = config_key_unlock_pkg::GATE_ANALOG;
            default: gate_of = config_key_unlock_pkg::GATE_OPEN;
        endcase
    endfunction

    // a write strobe aimed at one register offset
    function automatic logic write_hit(input logic en, input logic [7:0] a, input logic [7:0] t);
        write_hit = en && (a == t);
    endfunction

    // per-register write strobes; the key write itself is never gated
    always_comb begin
        write_key = write_hit(WR_EN, ADDR, `ADDR_UNLOCK_KEY); // [RULE_01]
        write_osc_control = write_hit(WR_EN, ADDR, `ADDR_OSC_CONTROL);
        write_trickle = write_hit(WR_EN, ADDR, `ADDR_TRICKLE);
        write_comp_ref = write_hit(WR_EN, ADDR, `ADDR_COMP_REF);
        write_osc_status = write_hit(WR_EN, ADDR, `ADDR_OSC_STATUS);
        write_configuration = write_hit(WR_EN, ADDR, `ADDR_CONFIGURATION);
    end

    // ----------------------------------------
    // key gate
    // ----------------------------------------

    // write permitted by the key as it stood before this write,
    // so the key write has to be the one just before the protected one
    always_comb begin
        gate = gate_of(ADDR);
        case (gate)
            config_key_unlock_pkg::GATE_OSC: begin
                allowed = (unlock_key == `KEY_OSC); // [RULE_02]
            end
            config_key_unlock_pkg::GATE_ANALOG: begin
                allowed = (unlock_key == `KEY_ANALOG); // [RULE_03]
            end
            default: begin
                allowed = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // unlock key
    // ----------------------------------------

    // a write to the key loads it, any other write spends it
    always_comb begin
        next_unlock_key = unlock_key;
        if (write_key) begin
            next_unlock_key = WDATA; // [RULE_01]
        end else if (WR_EN) begin
            next_unlock_key = `KEY_CLEAR; // [RULE_04]
        end
    end

    // refused writes spend the key as well, so a wrong guess buys nothing
    always_ff @(posedge MCLK) begin
        if (RST) begin
            unlock_key <= `RST_UNLOCK_KEY; // [RULE_01]
        end else begin
            unlock_key <= next_unlock_key;
        end
    end

    // ----------------------------------------
    // protected registers
    // ----------------------------------------

    // oscillator control; a refused write is silently dropped
    always_ff @(posedge MCLK) begin
        if (RST) begin
            osc_control <= `RST_OSC_CONTROL;
        end else if (write_osc_control && allowed) begin
            osc_control <= WDATA; // [RULE_02]
        end
    end

    // trickle charge
    always_ff @(posedge MCLK) begin
        if (RST) begin
            trickle <= `RST_TRICKLE;
        end else if (write_trickle && allowed) begin
            trickle <= WDATA; // [RULE_03]
        end
    end

    // comparator reference; low nibble reserved and held at zero
    always_ff @(posedge MCLK) begin
        if (RST) begin
            comp_ref <= `RST_COMP_REF;
        end else if (write_comp_ref && allowed) begin
            comp_ref <= {WDATA[7:4], 4'h0}; // [RULE_03]
        end
    end

    // ----------------------------------------
    // status and configuration
    // ----------------------------------------

    // oscillator status: only the lock bit is writable here,
    // the oscillator fields are not modelled and keep their reset value
    always_ff @(posedge MCLK) begin
        if (RST) begin
            osc_status <= `RST_OSC_STATUS;
        end else if (write_osc_status) begin
            osc_status[`BIT_SWITCH_LOCK] <= WDATA[`BIT_SWITCH_LOCK];
        end
    end

    // next configuration: pin level bit frozen while locked
    always_comb begin
        next_configuration = WDATA;
        if (osc_status[`BIT_SWITCH_LOCK]) begin
            next_configuration[`BIT_PIN_LEVEL] = configuration[`BIT_PIN_LEVEL]; // [RULE_05]
        end
    end

    // configuration register; the other bits still take the write
    always_ff @(posedge MCLK) begin
        if (RST) begin
            configuration <= `RST_CONFIGURATION;
        end else if (write_configuration) begin
            configuration <= next_configuration;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------

    // read mux; unmapped offsets read zero
    always_comb begin
        next_rdata = RDATA;
        if (RD_EN) begin
            case (ADDR)
                `ADDR_UNLOCK_KEY: begin
                    next_rdata = unlock_key;
                end
                `ADDR_OSC_STATUS: begin
                    next_rdata = osc_status;
                end
                `ADDR_OSC_CONTROL: begin
                    next_rdata = osc_control;
                end
                `ADDR_CONFIGURATION: begin
                    next_rdata = configuration;
                end
                `ADDR_TRICKLE: begin
                    next_rdata = trickle;
                end
                `ADDR_COMP_REF: begin
                    next_rdata = comp_ref;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    // read data registered, holds until the next read strobe
    always_ff @(posedge MCLK) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------

    // plain copies of their registers, no logic in between
    assign UNLOCK_KEY = unlock_key;
    assign OSC_CONTROL = osc_control;
    assign TRICKLE = trickle;
    assign COMP_REF = comp_ref;
    assign POWER_SWITCH_PIN_LEVEL = configuration[`BIT_PIN_LEVEL];

endmodule // config_key_unlock

// File: design/config_key_unlock_consts.svh
// constants for the unlock key register bank
`ifndef CONFIG_KEY_UNLOCK_CONSTS_SVH
`define CONFIG_KEY_UNLOCK_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_CONFIGURATION 8'h10
`define ADDR_OSC_STATUS 8'h1D
`define ADDR_UNLOCK_KEY 8'h1F
`define ADDR_TRICKLE 8'h20
`define ADDR_COMP_REF 8'h21
`define ADDR_OSC_CONTROL 8'h1C

// ----------------------------------------
// key values and fields
// ----------------------------------------
`define KEY_OSC 8'hA1
`define KEY_ANALOG 8'h9D
`define KEY_CLEAR 8'h00
`define BIT_SWITCH_LOCK 5
`define BIT_PIN_LEVEL 5

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_UNLOCK_KEY 8'h00
`define RST_OSC_STATUS 8'h20
`define RST_OSC_CONTROL 8'h00
`define RST_CONFIGURATION 8'h00
`define RST_TRICKLE 8'h00
`define RST_COMP_REF 8'hF0

`endif

// File: design/config_key_unlock_pkg.sv
// types for the unlock key register bank
package config_key_unlock_pkg;
    typedef enum logic [1:0] {
        GATE_OPEN = 2'b00,
        GATE_OSC = 2'b01,
        GATE_ANALOG = 2'b10
    } gate_e;
endpackage

// File: dv/config_key_unlock_monitor.sv
// assertion checker for the unlock key register bank
`timescale 1ns/1ps
module key_monitor (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic WR_EN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] UNLOCK_KEY,
    input wire logic [7:0] OSC_CONTROL,
    input wire logic [7:0] TRICKLE,
    input wire logic [7:0] COMP_REF
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    key_load_a: assert property (
        WR_EN && ADDR == 8'h1F |=> UNLOCK_KEY == $past(WDATA))
        else $error("key not loaded");
    key_clear_a: assert property (
        WR_EN && ADDR != 8'h1F |=> UNLOCK_KEY == 8'h00)
        else $error("key not cleared");
    osc_gate_a: assert property (
        WR_EN && ADDR == 8'h1C && UNLOCK_KEY != 8'hA1 |=> $stable(OSC_CONTROL))
        else $error("osc control written without key");
    osc_take_a: assert property (
        WR_EN && ADDR == 8'h1C && UNLOCK_KEY == 8'hA1 |=> OSC_CONTROL == $past(WDATA))
        else $error("keyed osc control write lost");
    trickle_gate_a: assert property (
        WR_EN && ADDR == 8'h20 && UNLOCK_KEY != 8'h9D |=> $stable(TRICKLE))
        else $error("trickle written without key");
    trickle_take_a: assert property (
        WR_EN && ADDR == 8'h20 && UNLOCK_KEY == 8'h9D |=> TRICKLE == $past(WDATA))
        else $error("keyed trickle write lost");
    comp_gate_a: assert property (
        WR_EN && ADDR == 8'h21 && UNLOCK_KEY != 8'h9D |=> $stable(COMP_REF))
        else $error("comparator reference written without key");
    comp_take_a: assert property (
        WR_EN && ADDR == 8'h21 && UNLOCK_KEY == 8'h9D |=> COMP_REF == {$past(WDATA[7:4]), 4'h0})
        else $error("keyed comparator reference write lost");
endmodule // key_monitor
bind config_key_unlock key_monitor i_key_monitor (.MCLK(MCLK), .RST(RST), .WR_EN(WR_EN),
    .ADDR(ADDR), .WDATA(WDATA), .UNLOCK_KEY(UNLOCK_KEY), .OSC_CONTROL(OSC_CONTROL),
    .TRICKLE(TRICKLE), .COMP_REF(COMP_REF));

// File: dv/tb_config_key_unlock.sv
// directed testbench for the unlock key register bank
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb_config_key_unlock;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic WR_EN = 1'b0;
    logic RD_EN = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    logic [7:0] RDATA;
    logic [7:0] UNLOCK_KEY;
    logic [7:0] OSC_CONTROL;
    logic [7:0] TRICKLE;
    logic [7:0] COMP_REF;
    logic POWER_SWITCH_PIN_LEVEL;
    int bad_count = 0;
    int compares = 0;
    config_key_unlock i_config_key_unlock (.MCLK(MCLK), .RST(RST), .WR_EN(WR_EN), .RD_EN(RD_EN),
        .ADDR(ADDR), .WDATA(WDATA), .RDATA(RDATA), .UNLOCK_KEY(UNLOCK_KEY),
        .OSC_CONTROL(OSC_CONTROL), .TRICKLE(TRICKLE), .COMP_REF(COMP_REF),
        .POWER_SWITCH_PIN_LEVEL(POWER_SWITCH_PIN_LEVEL));
    always #10 MCLK = ~MCLK;
    // one write, outputs settled on return
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        WR_EN <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
        WR_EN <= 1'b0;
        #1;
    endtask
    // one read, read data stands from the edge that takes the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge MCLK);
        RD_EN <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD_EN <= 1'b0;
        #1;
        `CHK(RDATA, e)
    endtask
    task automatic print_verdict;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // guard against a hung run
    initial begin
        #200000;
        bad_count++;
        print_verdict;
    end
    initial begin
        repeat (5) @(posedge MCLK);
        RST <= 1'b0;
        rd(8'h1F, 8'h00);
        `CHK(COMP_REF, 8'hF0)
        wr(8'h1C, 8'h5A);
        `CHK(OSC_CONTROL, 8'h00)
        wr(8'h1F, 8'h9D);
        wr(8'h1C, 8'h5A);
        `CHK(OSC_CONTROL, 8'h00)
        wr(8'h1F, 8'hA1);
        `CHK(UNLOCK_KEY, 8'hA1)
        rd(8'h1F, 8'hA1);
        wr(8'h1C, 8'h5A);
        `CHK(OSC_CONTROL, 8'h5A)
        `CHK(UNLOCK_KEY, 8'h00)
        rd(8'h1C, 8'h5A);
        wr(8'h1F, 8'hA1);
        wr(8'h20, 8'hA5);
        `CHK(TRICKLE, 8'h00)
        wr(8'h1F, 8'h9D);
        wr(8'h20, 8'hA5);
        `CHK(TRICKLE, 8'hA5)
        // an unrelated write in between spends the key
        wr(8'h1F, 8'h9D);
        wr(8'h11, 8'h00);
        wr(8'h21, 8'h30);
        `CHK(COMP_REF, 8'hF0)
        // the reserved low nibble reads back zero
        wr(8'h1F, 8'h9D);
        wr(8'h21, 8'h7F);
        `CHK(COMP_REF, 8'h70)
        rd(8'h21, 8'h70);
        wr(8'h10, 8'h20);
        `CHK(POWER_SWITCH_PIN_LEVEL, 1'b0)
        wr(8'h1D, 8'h00);
        wr(8'h10, 8'h20);
        `CHK(POWER_SWITCH_PIN_LEVEL, 1'b1)
        // locking again holds the level high against a clearing write
        wr(8'h1D, 8'h20);
        rd(8'h1D, 8'h20);
        wr(8'h10, 8'h00);
        `CHK(POWER_SWITCH_PIN_LEVEL, 1'b1)
        rd(8'h10, 8'h20);
        print_verdict;
    end
endmodule // tb_config_key_unlock
